// ==== pkg/asbg_map.vh ====
// Register offsets, field positions, reset values and timing constants of the break generator
`ifndef ASBG_MAP_VH
`define ASBG_MAP_VH
`define ASBG_ADDR_W          12
`define ASBG_OFS_CONTROL_ONE 12'h000
`define ASBG_OFS_CONTROL_TWO 12'h004
`define ASBG_OFS_CONTROL_THR 12'h008
`define ASBG_OFS_BAUD        12'h00C
`define ASBG_OFS_DATA        12'h010
`define ASBG_OFS_STATUS      12'h014
`define ASBG_BIT_WORD_LEN    0
`define ASBG_BIT_SEND_BREAK  0
`define ASBG_BIT_TX_ENABLE   1
`define ASBG_BIT_LIN_LONG    0
`define ASBG_ST_BUSY         0
`define ASBG_ST_BREAK        1
`define ASBG_ST_IDLE         2
`define ASBG_ST_BUF_FULL     3
`define ASBG_ST_PEND_IDLE    4
`define ASBG_ST_HDR_OVER     5
`define ASBG_BAUD_W          16
`define ASBG_BAUD_RST        16'h0001
`define ASBG_BREAK_SHORT     5'h0A
`define ASBG_BREAK_LONG      5'h0B
`define ASBG_BREAK_LIN       5'h0D
`define ASBG_IDLE_BITS       5'h0A
`define ASBG_FRAME_SHORT     5'h0A
`define ASBG_FRAME_LONG      5'h0B
`define ASBG_LIN_HEADER_MAX  6'h31
`define ASBG_LIN_BREAK_MAX   5'h0E
`endif

// ==== rtl/asbg_baud_tick.v ====
// Baud-rate divider producing a one-cycle bit-time enable
`timescale 1ns/1ns
module asbg_baud_tick #(
	parameter W = 16
) (
	// Clock and reset
	input  wire         hclk,
	input  wire         hresetn,
	// Control
	input  wire         run,
	input  wire [W-1:0] divisor,
	// Bit-time enable
	output reg          tick
);
	reg [W-1:0] cnt_reg;

	// Held in reset while stopped so the first tick falls a full bit after start
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= {W{1'b0}};
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= {W{1'b0}};
			tick    <= 1'b0;
		end else if (cnt_reg >= divisor - {{(W-1){1'b0}}, 1'b1} || divisor == {W{1'b0}}) begin
			cnt_reg <= {W{1'b0}};
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
			tick    <= 1'b0;
		end
	end
endmodule

// ==== rtl/asbg_skid_buf.v ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module asbg_skid_buf #(
	parameter W = 9
) (
	// Clock and reset
	input  wire         hclk,
	input  wire         hresetn,
	// Filling side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// Draining side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:1];
	reg         wr_reg;
	reg         rd_reg;
	reg [1:0]   cnt_reg;
	wire        push;
	wire        pop;

	assign in_ready  = (cnt_reg != 2'h2);
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = mem[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg  <= 1'b0;
			rd_reg  <= 1'b0;
			cnt_reg <= 2'h0;
			mem[0]  <= {W{1'b0}};
			mem[1]  <= {W{1'b0}};
		end else begin
			if (push) begin
				mem[wr_reg] <= in_data;
				wr_reg      <= ~wr_reg;
			end
			if (pop)
				rd_reg <= ~rd_reg;
			if (push && !pop)
				cnt_reg <= cnt_reg + 2'h1;
			else if (pop && !push)
				cnt_reg <= cnt_reg - 2'h1;
		end
	end
endmodule

// ==== rtl/asbg_top.v ====
// Asynchronous serial transmitter with break and idle generation behind an AHB-Lite slave
// Operation
// - Setting send_break and clearing it again yields exactly one break on the serial output.
// - A break lasts 10 low bits with word_length_select and lin_long_break clear and 11 with word_length_select set, never doubled.
// - While send_break stays set, breaks follow one another back to back and stop once it clears.
// - Clearing then setting tx_enable queues one idle request, which the transmitter sends ahead of any queued break or data.
// - An idle request followed at once by a break request gives the idle character then a correct break.
// - The idle character holds the line high for 10 bit times.
// - With lin_long_break set and word_length_select clear each break lasts 13 low bits.
// - A LIN header of break, synch and identifier fields must stay within 49 bit times.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "asbg_map.vh"
module asbg_top #(
	parameter BAUD_W = `ASBG_BAUD_W
) (
	// Clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Serial line
	output reg         serial_tx_pin
);
	localparam S_IDLE  = 3'h0;
	localparam S_DATA  = 3'h1;
	localparam S_IDLCH = 3'h2;
	localparam S_BREAK = 3'h3;
	localparam S_ALIGN = 3'h4;

	// Registers
	reg              word_length_select_reg;
	reg              send_break_reg;
	reg              tx_enable_reg;
	reg              lin_long_break_reg;
	reg [BAUD_W-1:0] baud_reg;
	reg              idle_pend_reg;
	reg              break_pend_reg;
	// Bus phase capture
	reg              wr_pend_reg;
	reg [11:0]       wr_addr_reg;
	reg              rd_pend_reg;
	// Transmitter
	reg [2:0]        state_reg;
	reg [4:0]        bit_cnt_reg;
	reg [9:0]        shift_reg;
	reg [4:0]        frame_len_reg;
	wire             tick;
	wire             buf_in_ready;
	wire             buf_out_valid;
	wire [8:0]       buf_out_data;
	wire             buf_pop;
	wire             addr_phase;
	wire             data_write;
	wire [4:0]       break_len;
	wire             busy;
	// LIN header watch
	reg              hdr_run_reg;
	reg              hdr_frm_reg;
	reg              hdr_over_reg;
	reg [5:0]        hdr_cnt_reg;
	wire             lin_mode;
	wire             break_start;
	wire             frame_done;

	function [11:0] low_addr;
		input [31:0] a;
		begin
			low_addr = a[11:0];
		end
	endfunction

	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addr_phase = hsel && hready && htrans[1];
	assign data_write = wr_pend_reg && (wr_addr_reg == `ASBG_OFS_DATA);
	// Waiting at a bit boundary with nothing queued counts as quiet
	assign busy       = (state_reg != S_IDLE && state_reg != S_ALIGN) || buf_out_valid || idle_pend_reg ||
		break_pend_reg || send_break_reg;
	assign lin_mode    = lin_long_break_reg && !word_length_select_reg;
	assign break_start = state_reg == S_ALIGN && tick && !idle_pend_reg && (break_pend_reg || send_break_reg);
	assign frame_done  = state_reg == S_DATA && tick && bit_cnt_reg == frame_len_reg;

	// Break length chosen from word length and LIN setting, fixed count so never doubled
	assign break_len = word_length_select_reg ? `ASBG_BREAK_LONG :
		(lin_long_break_reg ? `ASBG_BREAK_LIN : `ASBG_BREAK_SHORT);

	// Address phase captured; write data lands in the following cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			rd_pend_reg <= addr_phase && !hwrite;
			if (addr_phase)
				wr_addr_reg <= low_addr(haddr);
		end
	end

	// Read data registered at the address phase, shown in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= 32'h00000000;
			if (low_addr(haddr) == `ASBG_OFS_CONTROL_ONE)
				hrdata[`ASBG_BIT_WORD_LEN] <= word_length_select_reg;
			else if (low_addr(haddr) == `ASBG_OFS_CONTROL_TWO) begin
				hrdata[`ASBG_BIT_SEND_BREAK] <= send_break_reg;
				hrdata[`ASBG_BIT_TX_ENABLE]  <= tx_enable_reg;
			end else if (low_addr(haddr) == `ASBG_OFS_CONTROL_THR)
				hrdata[`ASBG_BIT_LIN_LONG] <= lin_long_break_reg;
			else if (low_addr(haddr) == `ASBG_OFS_BAUD)
				hrdata[BAUD_W-1:0] <= baud_reg;
			else if (low_addr(haddr) == `ASBG_OFS_STATUS) begin
				hrdata[`ASBG_ST_BUSY]      <= busy;
				hrdata[`ASBG_ST_BREAK]     <= (state_reg == S_BREAK);
				hrdata[`ASBG_ST_IDLE]      <= (state_reg == S_IDLCH);
				hrdata[`ASBG_ST_BUF_FULL]  <= !buf_in_ready;
				hrdata[`ASBG_ST_PEND_IDLE] <= idle_pend_reg;
				hrdata[`ASBG_ST_HDR_OVER]  <= hdr_over_reg;
			end
		end
	end

	// Register writes and request latching
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			word_length_select_reg <= 1'b0;
			send_break_reg         <= 1'b0;
			tx_enable_reg          <= 1'b0;
			lin_long_break_reg     <= 1'b0;
			baud_reg               <= `ASBG_BAUD_RST;
			idle_pend_reg          <= 1'b0;
			break_pend_reg         <= 1'b0;
		end else begin
			// Break taken by the transmitter; a new rising edge of send_break below wins
			if (state_reg == S_ALIGN && tick && !idle_pend_reg)
				break_pend_reg <= 1'b0;
			if (state_reg == S_ALIGN && tick && idle_pend_reg)
				idle_pend_reg <= 1'b0;
			if (wr_pend_reg) begin
				if (wr_addr_reg == `ASBG_OFS_CONTROL_ONE)
					word_length_select_reg <= hwdata[`ASBG_BIT_WORD_LEN];
				else if (wr_addr_reg == `ASBG_OFS_CONTROL_TWO) begin
					send_break_reg <= hwdata[`ASBG_BIT_SEND_BREAK];
					tx_enable_reg  <= hwdata[`ASBG_BIT_TX_ENABLE];
					// Rising edge of send_break queues one break
					if (hwdata[`ASBG_BIT_SEND_BREAK] && !send_break_reg)
						break_pend_reg <= 1'b1;
					// Enable going low then high again queues one idle character
					if (hwdata[`ASBG_BIT_TX_ENABLE] && !tx_enable_reg)
						idle_pend_reg <= 1'b1;
				end else if (wr_addr_reg == `ASBG_OFS_CONTROL_THR)
					lin_long_break_reg <= hwdata[`ASBG_BIT_LIN_LONG];
				else if (wr_addr_reg == `ASBG_OFS_BAUD)
					baud_reg <= hwdata[BAUD_W-1:0];
			end
		end
	end

	// Data words of 8 or 9 bits wait here while the line is busy
	asbg_skid_buf #(
		.W(9)
	) u_buf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (data_write && tx_enable_reg),
		.in_ready  (buf_in_ready),
		.in_data   (hwdata[8:0]),
		.out_valid (buf_out_valid),
		.out_ready (buf_pop),
		.out_data  (buf_out_data)
	);

	asbg_baud_tick #(
		.W(BAUD_W)
	) u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     (tx_enable_reg),
		.divisor (baud_reg),
		.tick    (tick)
	);

	// Data leaves the buffer only at a bit boundary; a data write while the buffer is full is dropped, the writer never stalls
	assign buf_pop = tx_enable_reg && tick && state_reg == S_ALIGN && !idle_pend_reg &&
		!break_pend_reg && !send_break_reg;

	// LIN header watch: bit times from a long break to the end of the second frame after it;
	// a slow writer between synch and identifier shows up here as an overrun
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hdr_run_reg  <= 1'b0;
			hdr_frm_reg  <= 1'b0;
			hdr_cnt_reg  <= 6'h00;
			hdr_over_reg <= 1'b0;
		end else if (!tx_enable_reg) begin
			hdr_run_reg <= 1'b0;
		end else if (break_start) begin
			hdr_run_reg  <= lin_mode;
			hdr_frm_reg  <= 1'b0;
			hdr_cnt_reg  <= 6'h00;
			hdr_over_reg <= 1'b0;
		end else if (hdr_run_reg && tick) begin
			if (hdr_cnt_reg >= `ASBG_LIN_HEADER_MAX)
				hdr_over_reg <= 1'b1;
			// Saturates so a header that never ends cannot wrap back into range
			if (hdr_cnt_reg != {6{1'b1}})
				hdr_cnt_reg <= hdr_cnt_reg + 6'h01;
			if (frame_done) begin
				hdr_frm_reg <= 1'b1;
				if (hdr_frm_reg)
					hdr_run_reg <= 1'b0;
			end
		end
	end

	// Transmit sequencer; every step except leaving S_IDLE waits on the baud tick
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg     <= S_IDLE;
			bit_cnt_reg   <= 5'h00;
			shift_reg     <= 10'h3FF;
			frame_len_reg <= `ASBG_FRAME_SHORT;
			serial_tx_pin <= 1'b1;
		end else if (!tx_enable_reg) begin
			state_reg     <= S_IDLE;
			bit_cnt_reg   <= 5'h00;
			serial_tx_pin <= 1'b1;
		end else begin
			case (state_reg)
				S_IDLE: begin
					serial_tx_pin <= 1'b1;
					state_reg     <= S_ALIGN;
				end
				// Line high, waiting for the next bit boundary
				S_ALIGN: begin
					serial_tx_pin <= 1'b1;
					if (tick) begin
						bit_cnt_reg <= 5'h01;
						if (idle_pend_reg) begin
							state_reg <= S_IDLCH;
						end else if (break_pend_reg || send_break_reg) begin
							serial_tx_pin <= 1'b0;
							state_reg     <= S_BREAK;
						end else if (buf_out_valid) begin
							serial_tx_pin <= 1'b0;
							shift_reg     <= word_length_select_reg ? {1'b1, buf_out_data} :
								{2'b11, buf_out_data[7:0]};
							frame_len_reg <= word_length_select_reg ? `ASBG_FRAME_LONG :
								`ASBG_FRAME_SHORT;
							state_reg     <= S_DATA;
						end
					end
				end
				// Idle character: line high for ten bits
				S_IDLCH: begin
					serial_tx_pin <= 1'b1;
					if (tick) begin
						if (bit_cnt_reg == `ASBG_IDLE_BITS)
							state_reg <= S_ALIGN;
						else
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
				end
				// Break: low for exactly break_len bit times
				S_BREAK: begin
					serial_tx_pin <= 1'b0;
					if (tick) begin
						if (bit_cnt_reg == break_len) begin
							// A high bit between held breaks keeps them apart, so none reads as doubled
							serial_tx_pin <= 1'b1;
							state_reg     <= S_ALIGN;
						end else
							bit_cnt_reg <= bit_cnt_reg + 5'h01;
					end
				end
				S_DATA: begin
					if (tick) begin
						if (bit_cnt_reg == frame_len_reg) begin
							serial_tx_pin <= 1'b1;
							state_reg     <= S_ALIGN;
						end else begin
							serial_tx_pin <= shift_reg[0];
							shift_reg     <= {1'b1, shift_reg[9:1]};
							bit_cnt_reg   <= bit_cnt_reg + 5'h01;
						end
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== sim/asbg_remote_node.sv ====
// Remote serial node measuring low and high run lengths on the line
`timescale 1ns/1ns
module asbg_remote_node (
	// Clock and line
	input wire hclk,
	input wire line
);
	int n_low = 0;
	int run = 0;
	int last_low = 0;
	int last_high = 0;
	int cyc = 0;
	int fall_at = 0;
	reg prev = 1'b1;
	// Every low run is counted once, so a doubled break shows as one long run
	always @(posedge hclk) begin
		if (line !== prev) begin
			if (prev == 1'b0) begin
				last_low <= run;
				n_low <= n_low + 1;
			end else begin
				last_high <= run;
				fall_at   <= cyc;
			end
			run <= 1;
		end else
			run <= run + 1;
		prev <= line;
		cyc <= cyc + 1;
	end
endmodule

// ==== sim/asbg_top_properties.sv ====
// Port-level assertions for the break generator
`timescale 1ns/1ns
module asbg_top_properties #(
	parameter BAUD_W = 16
) (
	// Clock and reset
	input wire        hclk,
	input wire        hresetn,
	// Bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	// Line
	input wire        serial_tx_pin
);
	reg [11:0]       a_reg;
	reg              w_reg;
	reg [BAUD_W-1:0] div_reg;
	reg              txen_reg;
	reg [31:0]       lc_reg;
	wire             rd = hsel & hready & htrans[1] & !hwrite;
	// Shadow of divisor and enable, so bit lengths are judged against the live setting
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_reg <= 12'h000; w_reg <= 1'b0; txen_reg <= 1'b0; lc_reg <= 32'h0;
			div_reg <= {{(BAUD_W-1){1'b0}}, 1'b1};
		end else begin
			a_reg <= haddr[11:0];
			w_reg <= hsel & hready & htrans[1] & hwrite;
			lc_reg <= serial_tx_pin ? 32'h0 : lc_reg + 32'h1;
			if (w_reg && a_reg == 12'h00C)
				div_reg <= (hwdata[BAUD_W-1:0] == {BAUD_W{1'b0}}) ? {{(BAUD_W-1){1'b0}}, 1'b1} :
					hwdata[BAUD_W-1:0];
			if (w_reg && a_reg == 12'h004)
				txen_reg <= hwdata[1];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_READY_ONE: assert property (hreadyout) else $error("hreadyout low");
	AST_RESP_OKAY: assert property (!hresp) else $error("hresp not okay");
	AST_UNMAPPED_ZERO: assert property (rd && haddr[11:0] == 12'h020 |=> hrdata == 32'h0) else $error("unmapped read");
	AST_HRDATA_HOLD: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
	AST_BREAK_MAX: assert property (lc_reg <= 32'd13 * div_reg) else $error("low too long");
	AST_LOW_WHOLE_BITS: assert property ($rose(serial_tx_pin) |-> lc_reg % div_reg == 0) else $error("part bit");
	AST_TXEN_OFF_HIGH: assert property (!txen_reg [*3] |-> serial_tx_pin) else $error("line low when off");
	AST_BREAK_ENDS: assert property (lc_reg == 32'd13 * div_reg |=> serial_tx_pin) else $error("break overran");
	cover property ($rose(serial_tx_pin) && lc_reg == 32'd10 * div_reg);
	cover property ($rose(serial_tx_pin) && lc_reg == 32'd11 * div_reg);
	cover property ($rose(serial_tx_pin) && lc_reg == 32'd13 * div_reg);
endmodule
bind asbg_top asbg_top_properties #(.BAUD_W(BAUD_W)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .serial_tx_pin(serial_tx_pin));

// ==== sim/async_serial_break_generator_bench.sv ====
// Self-checking bench for the break generator
`timescale 1ns/1ns
module async_serial_break_generator_bench;
	localparam D = 2;
	reg hclk = 0, hresetn = 0, hwrite = 0;
	reg [31:0] haddr = 0, hwdata = 0;
	reg [1:0] htrans = 0;
	wire hreadyout, hresp, serial_tx_pin;
	wire [31:0] hrdata;
	int mismatches = 0, n_compared = 0;
	reg [31:0] rv;
	always #10 hclk = ~hclk;
	asbg_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .serial_tx_pin(serial_tx_pin));
	asbg_remote_node node_u (.hclk(hclk), .line(serial_tx_pin));
	task automatic cmp(input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input [11:0] a, input w, input [31:0] d);
		haddr <= {20'h0, a}; hwrite <= w; htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask
	task automatic wait_low(input int n);
		for (int k = 0; k < 3000 && node_u.n_low < n; k++) @(posedge hclk);
		cmp(node_u.n_low, n);
	endtask
	task automatic t_break(input [31:0] wls, input [31:0] lin, input [31:0] bits);
		int n;
		n = node_u.n_low;
		xfer(12'h000, 1, wls); xfer(12'h008, 1, lin);
		xfer(12'h004, 1, 3); xfer(12'h004, 1, 2);
		wait_low(n + 1);
		repeat (40 * D) @(posedge hclk);
		cmp(node_u.n_low, n + 1);
		cmp(node_u.last_low, bits * D);
	endtask
	task automatic t_repeat;
		int n;
		n = node_u.n_low;
		xfer(12'h004, 1, 3);
		wait_low(n + 2);
		cmp(node_u.last_low, 10 * D);
		xfer(12'h004, 1, 2);
		repeat (15 * D) @(posedge hclk);
		n = node_u.n_low;
		repeat (40 * D) @(posedge hclk);
		cmp(node_u.n_low, n);
	endtask
	task automatic t_idle;
		int n, t0;
		n = node_u.n_low;
		xfer(12'h004, 1, 0); xfer(12'h004, 1, 2);
		t0 = node_u.cyc;
		xfer(12'h004, 1, 3); xfer(12'h004, 1, 2);
		wait_low(n + 1);
		cmp(node_u.last_high >= 10 * D, 1);
		cmp(node_u.fall_at - t0 >= 10 * D && node_u.fall_at - t0 <= 14 * D, 1);
		repeat (12 * D) @(posedge hclk);
		cmp(node_u.last_low, 10 * D);
	endtask
	// Four words back to back must outrun a two-entry buffer plus the shifter
	task automatic t_buffer;
		for (int i = 0; i < 4; i++) xfer(12'h010, 1, 32'h55);
		xfer(12'h014, 0, 0);
		cmp(rv[3], 1);
		for (int k = 0; k < 2000 && rv[0] !== 1'b0; k++) xfer(12'h014, 0, 0);
		cmp(rv, 0);
		xfer(12'h020, 0, 0);
		cmp(rv, 0);
	endtask
	// LIN header: break, synch and identifier queued at once, then with a long synch-to-identifier gap
	task automatic t_lin(input int gap);
		xfer(12'h000, 1, 0); xfer(12'h008, 1, 1);
		xfer(12'h004, 1, 3); xfer(12'h004, 1, 2);
		xfer(12'h010, 1, 32'h55);
		repeat (gap * D) @(posedge hclk);
		xfer(12'h010, 1, 32'h3C);
		xfer(12'h014, 0, 0);
		for (int k = 0; k < 500 && rv[0] !== 1'b0; k++) xfer(12'h014, 0, 0);
		cmp(rv[0], 0);
		cmp(rv[5], gap > 20);
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (25000) @(posedge hclk);
		mismatches++;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge hclk);
		cmp({hrdata[30:0], serial_tx_pin}, 1);
		hresetn <= 1;
		@(posedge hclk);
		xfer(12'h00C, 1, D);
		t_break(1, 0, 11);
		t_break(0, 1, 13);
		t_break(0, 0, 10);
		t_repeat;
		t_idle;
		t_buffer;
		t_lin(0);
		t_lin(40);
		tally_and_finish;
	end
endmodule
